// [verilog/des_defs.vh]
`ifndef DES_DEFS_VH
`define DES_DEFS_VH
`define DES_ADDR_W 4
`define DES_OFF_STATUS 4'h0
`define DES_OFF_MASK 4'h1
`define DES_OFF_CONFIG 4'h2
`define DES_OFF_TXCTL 4'h3
`define DES_BIT_TXDONE 0
`define DES_BIT_TXIDLE 1
`define DES_BIT_TXDU 2
`define DES_BIT_REARLY 3
`define DES_BIT_RX_ERROR_FLAG 4
`define DES_BIT_TXUF 5
`define DES_BIT_RXDONE 6
`define DES_BIT_RBU 7
`define DES_BIT_ABN 15
`define DES_BIT_NRM 16
`define DES_NORMAL_MASK 8'h45
`define DES_ABN_MASK 8'hba
`define DES_CFG_EARLY_ON 31
`define DES_CFG_THR_LSB 21
`define DES_RST_STATUS 8'h00
`define DES_RST_MASK 8'h00
`define DES_RST_CONFIG 32'h00000000
`define DES_TXD0_UF_BIT 1
`define DES_TXD1_IRQ_BIT 31
`endif

// [verilog/des_status.v]
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
`include "des_defs.vh"
// What this block does
// - No receive buffer: set bit 7, suspend receive
// - Bit 7 only after a buffer existed
// - Bit 7 not counted; one clear
// - Frame received, status written: set bit 6
// - Transmit FIFO empty mid-packet: set bit 5
// - After underflow, walk descriptors to last
// - Write underflow status bit 1 to last
// - Then transmit the next packet
// - Receive error after partial store: bit 4
// - Unmasked receive error interrupts, packet aborted
// - Early receive at long-word threshold: bit 3
// - Bit 3 cleared by receive done/error
// - No transmit descriptor at start: bit 2 if idle or sending, suspend if idle
// - Bit 2 not counted; one clear
// - Bit 1 high while transmitter idle
// - Frame done with request bit: bit 0
// - Write 1 clears (not bit 1, which follows idle), 0 leaves unchanged
// - Normal summary ORs unmasked bits 0,2,6
// - Abnormal summary ORs unmasked abnormal bits
module des_status #(
   parameter THR_W = 8
) (
   input wire core_clk,
   input wire nrst,
   input wire [`DES_ADDR_W-1:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata,
   input wire rx_buf_avail,
   input wire rx_frame_done,
   input wire rx_media_error,
   input wire rx_word_moved,
   input wire rx_frame_start,
   input wire tx_fifo_empty,
   input wire tx_frame_active,
   input wire tx_frame_done,
   input wire tx_desc_avail,
   input wire tx_desc_last,
   input wire tx_desc_irq_bit,
   input wire tx_desc_ack,
   input wire tx_start,
   output reg rx_suspend,
   output reg rx_abort,
   output reg tx_suspend,
   output wire tx_desc_fetch,
   output wire tx_data_fetch,
   output reg tx_status_write,
   output reg [31:0] tx_desc_word0,
   output wire irq_out_n,
   output wire normal_summary,
   output wire abnormal_summary
);
   localparam TX_IDLE = 5'h01;
   localparam TX_SEND = 5'h02;
   localparam TX_WALK = 5'h04;
   localparam TX_WBACK = 5'h08;
   localparam TX_SUSP = 5'h10;

   reg [7:0] sts_q;
   reg [7:0] sts_d;
   reg [7:0] mask_q;
   reg [31:0] cfg_q;
   reg [4:0] tx_st_q;
   reg [4:0] tx_st_d;
   reg rx_had_buf_q;
   reg rx_part_q;
   reg [THR_W-1:0] rx_words_q;
   reg rx_early_done_q;

   wire wr_sts = reg_wr && (reg_addr == `DES_OFF_STATUS);
   wire [7:0] clr = wr_sts ? reg_wdata[7:0] : 8'h00;
   wire [7:0] unmasked = sts_q & mask_q;
   wire [THR_W-1:0] thr = cfg_q[`DES_CFG_THR_LSB +: THR_W];
   wire tx_idle = (tx_st_q == TX_IDLE);
   wire rbu_ev = rx_had_buf_q && !rx_buf_avail && !rx_suspend;
   wire uf_ev = (tx_st_q == TX_SEND) && tx_frame_active && tx_fifo_empty;
   wire rx_error_flag_ev = rx_media_error && rx_part_q;
   wire early_ev = cfg_q[`DES_CFG_EARLY_ON] && (thr != {THR_W{1'b0}}) &&
      !rx_early_done_q && rx_word_moved &&
      (rx_words_q + 1'b1 == thr);
   wire txdu_ev = !tx_desc_avail && (tx_st_q == TX_SEND || tx_st_q == TX_IDLE) &&
      tx_start;
   wire txdone_ev = (tx_st_q == TX_SEND) && tx_frame_done && tx_desc_irq_bit;

   assign normal_summary = |(unmasked & `DES_NORMAL_MASK);
   assign abnormal_summary = |(unmasked & `DES_ABN_MASK);
   assign irq_out_n = !(normal_summary || abnormal_summary);
   assign tx_desc_fetch = (tx_st_q == TX_WALK);
   assign tx_data_fetch = (tx_st_q == TX_SEND) && !uf_ev;

   // Set wins over a same-cycle clear
   always @* begin
      sts_d = sts_q & ~clr;
      if (txdone_ev)
         sts_d[`DES_BIT_TXDONE] = 1'b1;
      sts_d[`DES_BIT_TXIDLE] = tx_idle;
      if (txdu_ev)
         sts_d[`DES_BIT_TXDU] = 1'b1;
      if (early_ev)
         sts_d[`DES_BIT_REARLY] = 1'b1;
      if (rx_error_flag_ev)
         sts_d[`DES_BIT_RX_ERROR_FLAG] = 1'b1;
      if (uf_ev)
         sts_d[`DES_BIT_TXUF] = 1'b1;
      if (rx_frame_done)
         sts_d[`DES_BIT_RXDONE] = 1'b1;
      if (rbu_ev)
         sts_d[`DES_BIT_RBU] = 1'b1;
      if (rx_frame_done || rx_error_flag_ev)
         sts_d[`DES_BIT_REARLY] = 1'b0;
   end

   always @* begin
      tx_st_d = tx_st_q;
      case (tx_st_q)
         TX_IDLE: begin
            if (tx_start)
               tx_st_d = tx_desc_avail ? TX_SEND : TX_SUSP;
         end
         TX_SEND: begin
            if (uf_ev)
               tx_st_d = tx_desc_last ? TX_WBACK : TX_WALK;
            else if (tx_frame_done)
               tx_st_d = TX_IDLE;
         end
         TX_WALK: begin
            if (tx_desc_ack && tx_desc_last)
               tx_st_d = TX_WBACK;
         end
         TX_WBACK: begin
            if (tx_desc_ack)
               tx_st_d = tx_desc_avail ? TX_SEND : TX_SUSP;
         end
         TX_SUSP: begin
            if (tx_desc_avail && tx_start)
               tx_st_d = TX_SEND;
         end
         default: tx_st_d = TX_IDLE;
      endcase
   end

   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         sts_q <= `DES_RST_STATUS;
         mask_q <= `DES_RST_MASK;
         cfg_q <= `DES_RST_CONFIG;
         tx_st_q <= TX_IDLE;
         rx_had_buf_q <= 1'b0;
         rx_part_q <= 1'b0;
         rx_words_q <= {THR_W{1'b0}};
         rx_early_done_q <= 1'b0;
         rx_suspend <= 1'b0;
         rx_abort <= 1'b0;
         tx_suspend <= 1'b0;
         tx_status_write <= 1'b0;
         tx_desc_word0 <= 32'h00000000;
         reg_rdata <= 32'h00000000;
      end else begin
         sts_q <= sts_d;
         tx_st_q <= tx_st_d;
         if (reg_wr && reg_addr == `DES_OFF_MASK)
            mask_q <= reg_wdata[7:0];
         if (reg_wr && reg_addr == `DES_OFF_CONFIG)
            cfg_q <= reg_wdata;
         // Availability seen once arms the unavailable flag
         if (rx_buf_avail)
            rx_had_buf_q <= 1'b1;
         if (rbu_ev)
            rx_suspend <= 1'b1;
         else if (rx_buf_avail)
            rx_suspend <= 1'b0;
         rx_abort <= rx_error_flag_ev;
         if (rx_frame_start || rx_frame_done || rx_error_flag_ev) begin
            rx_part_q <= 1'b0;
            rx_words_q <= {THR_W{1'b0}};
            rx_early_done_q <= 1'b0;
         end else if (rx_word_moved) begin
            rx_part_q <= 1'b1;
            rx_words_q <= rx_words_q + 1'b1;
            if (early_ev)
               rx_early_done_q <= 1'b1;
         end
         tx_suspend <= (tx_st_d == TX_SUSP);
         tx_status_write <= (tx_st_d == TX_WBACK);
         if (tx_st_d == TX_WBACK)
            tx_desc_word0 <= 32'h00000001 << `DES_TXD0_UF_BIT;
         reg_rdata <= 32'h00000000;
         if (reg_rd) begin
            case (reg_addr)
               `DES_OFF_STATUS: reg_rdata <= {15'h0000, normal_summary,
                  abnormal_summary, 7'h00, sts_q};
               `DES_OFF_MASK: reg_rdata <= {24'h000000, mask_q};
               `DES_OFF_CONFIG: reg_rdata <= cfg_q;
               `DES_OFF_TXCTL: reg_rdata <= {27'h0000000, tx_st_q};
               default: reg_rdata <= 32'h00000000;
            endcase
         end
      end
   end
endmodule // des_status

// [bench/des_status_assertions.sv]
`timescale 1ns/1ns
module des_status_assertions (
   input wire core_clk,
   input wire nrst,
   input wire [3:0] reg_addr,
   input wire reg_rd,
   input wire [31:0] reg_rdata,
   input wire rx_buf_avail,
   input wire rx_media_error,
   input wire rx_abort,
   input wire rx_suspend,
   input wire tx_desc_fetch,
   input wire tx_data_fetch,
   input wire tx_status_write,
   input wire [31:0] tx_desc_word0,
   input wire irq_out_n,
   input wire normal_summary,
   input wire abnormal_summary
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   a_rd_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside read slot");
   a_unmapped_zero: assert property ($past(reg_rd) && $past(reg_addr) > 4'h3 |-> !reg_rdata)
      else $error("unmapped read not zero");
   a_rx_suspend: assert property ($fell(rx_buf_avail) |-> ##[1:2] rx_suspend)
      else $error("receive not suspended");
   a_abort_cause: assert property (rx_abort |-> $past(rx_media_error))
      else $error("abort without error");
   a_wb_bit: assert property (tx_status_write |-> tx_desc_word0[1])
      else $error("writeback without underflow bit");
   a_wb_nodata: assert property (tx_status_write |-> !tx_data_fetch)
      else $error("data fetch during writeback");
   a_walk_nodata: assert property (tx_desc_fetch |-> !tx_data_fetch)
      else $error("data fetch during walk");
   a_irq_summary: assert property (irq_out_n == !(normal_summary || abnormal_summary))
      else $error("interrupt line disagrees");
   c_abort: cover property (rx_abort);
   c_wback: cover property (tx_status_write);
   c_buf_lost: cover property ($fell(rx_buf_avail));
endmodule // des_status_assertions

// [bench/des_desc_mem.sv]
`timescale 1ns/1ns
module des_desc_mem (
   input wire core_clk,
   input wire nrst,
   input wire req,
   input wire [3:0] delay,
   output reg ack
);
   reg [3:0] cnt_q;
   // Slow memory stretches the descriptor walk
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_q <= 4'h0;
         ack <= 1'b0;
      end else begin
         ack <= req && !ack && cnt_q == delay;
         cnt_q <= (req && !ack && cnt_q != delay) ? cnt_q + 4'h1 : 4'h0;
      end
   end
endmodule // des_desc_mem

// [bench/tb_dma_event_status_low_bits.sv]
`timescale 1ns/1ns
module tb_dma_event_status_low_bits;
   reg core_clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, rx_buf_avail = 0, tx_fifo_empty = 0;
   reg tx_frame_active = 0, tx_desc_avail = 0, tx_desc_last = 1, tx_desc_irq_bit = 1;
   reg [3:0] reg_addr = 0, dly = 0;
   reg [5:0] ev = 0;
   reg [31:0] reg_wdata = 0, rv;
   wire [31:0] reg_rdata, tx_desc_word0;
   wire rx_frame_done, rx_media_error, rx_word_moved, rx_frame_start, tx_start, tx_frame_done;
   wire rx_suspend, rx_abort, tx_suspend, tx_desc_fetch, tx_data_fetch, tx_status_write;
   wire tx_desc_ack, irq_out_n, normal_summary, abnormal_summary;
   integer fail_count = 0, tests_run = 0, cyc = 0, seed = 32'h50bc5007, st = 0, thr, i;
   assign {tx_frame_done, tx_start, rx_frame_start} = ev[5:3];
   assign {rx_word_moved, rx_media_error, rx_frame_done} = ev[2:0];
   des_status u_dut (.*);
   des_desc_mem u_mem (.core_clk(core_clk), .nrst(nrst), .req(tx_desc_fetch | tx_status_write),
      .delay(dly), .ack(tx_desc_ack));
   always #2 core_clk = ~core_clk;
   task chk(input [8*5:1] nm, input [31:0] seen, exp);
      begin
         tests_run = tests_run + 1;
         if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("CHECK FAILED %0s exp %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task acc(input w, input [3:0] a, input [31:0] d);
      begin
         @(posedge core_clk);
         reg_wr <= w;
         reg_rd <= !w;
         reg_addr <= a;
         reg_wdata <= d;
         @(posedge core_clk);
         reg_wr <= 0;
         reg_rd <= 0;
         #1 rv = reg_rdata;
      end
   endtask
   task pulse(input [5:0] m);
      begin
         @(posedge core_clk) ev <= m;
         @(posedge core_clk) ev <= 0;
      end
   endtask
   task stat(input [7:0] e);
      begin
         st = e;
         acc(0, 0, 0);
         chk("state", rv[7:0] & 8'hfd, st);
      end
   endtask
   task tend; $display("test done, %0d checks", tests_run); endtask
   task conclude;
      begin
         $display("checks %0d, mismatches %0d", tests_run, fail_count);
         if (fail_count == 0 && tests_run > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   always @(posedge core_clk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         fail_count = fail_count + 1;
         conclude;
      end
   end
   initial begin
      thr = 1 + {$random(seed)} % 4;
      dly = $random(seed);
      #9 nrst = 1;
      acc(0, 0, 0);
      chk("reset", rv, 32'h2);
      acc(0, 4'h9, 0);
      chk("unmap", rv, 0);
      for (i = 0; i < 4; i = i + 1)
         @(posedge core_clk) rx_buf_avail <= ~rx_buf_avail;
      acc(1, 0, 32'h7f);
      stat(8'h80);
      chk("rxsus", rx_suspend, 1);
      acc(1, 0, 32'h80);
      stat(0);
      pulse(6'h10);
      pulse(6'h10);
      stat(4);
      chk("txsus", tx_suspend, 1);
      acc(1, 0, 4);
      tend;
      acc(1, 2, 32'h80000000 | thr << 21);
      pulse(6'h08);
      repeat (thr) pulse(6'h04);
      stat(8);
      pulse(6'h01);
      stat(8'h40);
      pulse(6'h08);
      pulse(6'h04);
      pulse(6'h02);
      stat(8'h50);
      acc(1, 1, 32'h40);
      chk("nrm", {abnormal_summary, normal_summary, irq_out_n}, 3'h2);
      tend;
      acc(1, 0, 32'hff);
      @(posedge core_clk) tx_desc_avail <= 1;
      pulse(6'h10);
      @(posedge core_clk) {tx_frame_active, tx_fifo_empty} <= 2'h3;
      @(posedge core_clk) {tx_frame_active, tx_fifo_empty} <= 2'h0;
      for (i = 0; i < 300 && !tx_status_write; i = i + 1)
         @(posedge core_clk);
      #1 chk("wback", tx_desc_word0[1], 1);
      for (i = 0; i < 300 && tx_status_write; i = i + 1)
         @(posedge core_clk);
      pulse(6'h20);
      stat(8'h21);
      tend;
      acc(1, 0, 32'hff);
      pulse(6'h10);
      tx_desc_last <= 0;
      tx_desc_irq_bit <= 0;
      @(posedge core_clk) {tx_frame_active, tx_fifo_empty} <= 2'h3;
      @(posedge core_clk) {tx_frame_active, tx_fifo_empty} <= 2'h0;
      for (i = 0; i < 300 && !tx_desc_fetch; i = i + 1)
         @(posedge core_clk);
      repeat (3) @(posedge core_clk);
      #1 chk("walk", {tx_desc_fetch, tx_data_fetch}, 2'h2);
      @(posedge core_clk) tx_desc_last <= 1;
      for (i = 0; i < 300 && !tx_status_write; i = i + 1)
         @(posedge core_clk);
      #1 chk("wbk2", tx_desc_word0[1], 1);
      for (i = 0; i < 300 && tx_status_write; i = i + 1)
         @(posedge core_clk);
      pulse(6'h20);
      stat(8'h20);
      tend;
      conclude;
   end
endmodule // tb_dma_event_status_low_bits
bind des_status des_status_assertions u_chk (.*);
